// ===== hdl/cpg_pin_group.sv
`timescale 1ns/1ps
module cpg_pin_group #(
	parameter int PIN_COUNT = cpg_pkg::DFLT_PINS,
	parameter bit SPANNING = 1'b0, // Group may span ports
	parameter cpg_pkg::cpg_ptype_e PIN_TYPE = cpg_pkg::PT_OUTPUT
) (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic [7:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire logic I_IN_CLK,
	input wire logic I_IN_EN,
	input wire logic I_IN_RST,
	input wire logic I_OUT_CLK,
	input wire logic I_OUT_EN,
	input wire logic I_OUT_RST,
	input wire logic [PIN_COUNT-1:0] I_HW_OUT,
	input wire logic [PIN_COUNT-1:0] I_HW_OE,
	output logic [PIN_COUNT-1:0] O_HW_IN,
	input wire logic [PIN_COUNT-1:0] I_PIN_IN,
	output logic [PIN_COUNT-1:0] O_PIN_OUT,
	output logic [PIN_COUNT-1:0] O_PIN_OE,
	output logic [PIN_COUNT-1:0] O_PULL_UP,
	output logic [PIN_COUNT-1:0] O_PULL_DN
);
	import cpg_pkg::*;

	// Pins actually served; a single-port group stops at eight
	localparam int EFF_PINS = (!SPANNING && PIN_COUNT > PORT_PINS) ?
		PORT_PINS : PIN_COUNT;
	// Mask of served pins
	localparam logic [63:0] PIN_MASK = (EFF_PINS == MAX_PINS) ? '1 :
		((64'h1 << EFF_PINS) - 64'h1);
	// Drive mode after reset, chosen by pin type
	localparam cpg_drive_e DRV_RST =
		(PIN_TYPE == PT_INPUT) ? DM_HIZ_DIGITAL :
		(PIN_TYPE == PT_ANALOG) ? DM_HIZ_ANALOG :
		(PIN_TYPE == PT_BIDIR) ? DM_OD_LOW : DM_STRONG;
	// Hardware connections after reset, chosen by pin type
	localparam logic IN_HW_RST = (PIN_TYPE == PT_INPUT) ||
		(PIN_TYPE == PT_BIDIR);
	localparam logic OUT_HW_RST = (PIN_TYPE == PT_BIDIR);
	localparam logic BIDIR_RST = (PIN_TYPE == PT_BIDIR);
	// Configuration after reset
	localparam logic [CFG_W-1:0] CFG_RST =
		(CFG_W'(OUT_SYNC_RST) << B_OUT_SYNC) |
		(CFG_W'(BIDIR_RST) << B_BIDIR) |
		(CFG_W'(OUT_HW_RST) << B_OUT_HW) |
		(CFG_W'(IN_HW_RST) << B_IN_HW) |
		(CFG_W'(IN_SYNC_RST) << B_IN_SYNC);
	// Served pin count as shown in the status word
	localparam logic [6:0] EFF_CNT = 7'(EFF_PINS);

	// Whole module state
	typedef struct packed {
		logic [CFG_W-1:0] cfg; // Configuration word
		logic [63:0] out_val; // pin_output_value register
		logic [63:0][2:0] drv; // Per-pin drive mode
		logic [5:0] drv_idx; // Pin selected for mode access
		logic [63:0] lvl; // pin_level_readback register
		logic [63:0] pin_m; // First pin synchroniser flop
		logic [63:0] pin_s; // Second pin synchroniser flop
		logic [X_W-1:0] ext_m; // First control synchroniser flop
		logic [X_W-1:0] ext_s; // Second control synchroniser flop
		logic in_clk_d; // Delayed input clock for edges
		logic out_clk_d; // Delayed output clock for edges
		logic wait_n; // Low while a bus answer stands
		logic [31:0] rdata; // Read data
		logic [63:0] pin_out; // Pin output level
		logic [63:0] pin_oe; // Pin driver enable
		logic [63:0] pu; // Pull-up enable
		logic [63:0] pd; // Pull-down enable
		logic [63:0] hw_in; // Level to on-chip logic
	} cpg_top_s;

	cpg_top_s st_r;
	cpg_top_s st_nxt;

	cpg_sync_if in_if(); // Input stage link
	cpg_sync_if out_if(); // Output stage link

	logic [63:0] pin_ext; // Pins widened to the full group
	logic [63:0] hw_out_ext; // Logic data widened
	logic [63:0] hw_oe_ext; // Logic enables widened
	logic [63:0] src; // Data into the output stage
	logic fwd_lvl; // Forwarded clock level
	logic in_hw; // Input connected, bidir included
	logic out_hw; // Output connected, bidir included
	logic [63:0] drv_out; // Per-pin driver output
	logic [63:0] drv_oe; // Per-pin driver enable
	logic [63:0] drv_pu; // Per-pin pull-up
	logic [63:0] drv_pd; // Per-pin pull-down
	logic [31:0] rd_mux; // Selected read value
	logic [31:0] wmask; // Byte lane mask

	assign pin_ext = 64'(I_PIN_IN);
	assign hw_out_ext = 64'(I_HW_OUT);
	assign hw_oe_ext = 64'(I_HW_OE);

	// Bidirectional acts as both hardware connections
	assign in_hw = st_r.cfg[B_IN_HW] || st_r.cfg[B_BIDIR];
	assign out_hw = st_r.cfg[B_OUT_HW] || st_r.cfg[B_BIDIR];

	// Input stage controls; defaults are tick, enabled, no reset
	always_comb begin
		if (st_r.cfg[B_IN_CLK_EXT]) begin
			in_if.adv = st_r.ext_s[X_IN_CLK] && !st_r.in_clk_d;
		end else begin
			in_if.adv = 1'b1;
		end
		in_if.en = st_r.cfg[B_IN_EN_EXT] ? st_r.ext_s[X_IN_EN] : 1'b1;
		in_if.rst = st_r.cfg[B_IN_RST_EXT] && st_r.ext_s[X_IN_RST];
		in_if.mode = st_r.cfg[B_IN_SYNC +: 2];
		in_if.d = st_r.pin_s;
	end

	// Output stage controls, with the same defaults; the stage enable
	// also gates a forwarded clock in the source selection below
	always_comb begin
		if (st_r.cfg[B_OUT_CLK_EXT]) begin
			out_if.adv = st_r.ext_s[X_OUT_CLK] && !st_r.out_clk_d;
		end else begin
			out_if.adv = 1'b1;
		end
		out_if.en = st_r.cfg[B_OUT_EN_EXT] ? st_r.ext_s[X_OUT_EN] : 1'b1;
		out_if.rst = st_r.cfg[B_OUT_RST_EXT] && st_r.ext_s[X_OUT_RST];
		out_if.mode = st_r.cfg[B_OUT_SYNC +: 2];
		out_if.d = src;
	end

	// Output source: clock forwarding or data
	always_comb begin
		fwd_lvl = st_r.cfg[B_OUT_CLK_EXT] && st_r.ext_s[X_OUT_CLK] &&
			out_if.en;
		if (st_r.cfg[B_OUT_MODE +: 2] == OM_CLOCK) begin
			src = {64{fwd_lvl}};
		end else if (st_r.cfg[B_OUT_MODE +: 2] == OM_CLOCK_INV) begin
			src = {64{~fwd_lvl}};
		end else if (out_hw) begin
			src = hw_out_ext;
		end else begin
			src = st_r.out_val;
		end
	end

	cpg_sync_stage u_in_stage (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.s(in_if.stage)
	);

	cpg_sync_stage u_out_stage (
		.i_clk(I_CLK),
		.i_rst(I_SYS_RST),
		.s(out_if.stage)
	);

	// Per-pin driver according to its drive mode
	genvar gi;
	generate
		for (gi = 0; gi < MAX_PINS; gi++) begin : g_pin
			logic [2:0] mode; // Effective mode
			logic d; // Data for this pin
			logic hw_en; // Hardware enable for this pin
			always_comb begin
				mode = st_r.drv[gi];
				if (st_r.cfg[B_BUS_XCVR] && mode != DM_STRONG) begin
					mode = DM_OD_LOW;
				end
				d = out_if.q[gi];
				hw_en = !(st_r.cfg[B_OE_USED] && out_hw) || hw_oe_ext[gi];
				drv_out[gi] = d;
				drv_oe[gi] = 1'b0;
				drv_pu[gi] = 1'b0;
				drv_pd[gi] = 1'b0;
				// Pull-up and pull-down modes drive one level hard, a pull holds the other; up-down mode only pulls
				case (mode)
					DM_STRONG: begin
						drv_oe[gi] = 1'b1;
					end
					DM_OD_LOW: begin
						drv_out[gi] = 1'b0;
						drv_oe[gi] = !d;
					end
					DM_OD_HIGH: begin
						drv_out[gi] = 1'b1;
						drv_oe[gi] = d;
					end
					DM_PULL_UP: begin
						drv_out[gi] = 1'b0;
						drv_oe[gi] = !d;
						drv_pu[gi] = 1'b1;
					end
					DM_PULL_DOWN: begin
						drv_out[gi] = 1'b1;
						drv_oe[gi] = d;
						drv_pd[gi] = 1'b1;
					end
					DM_PULL_UPDN: begin
						drv_pu[gi] = d;
						drv_pd[gi] = !d;
					end
					default: begin
						drv_oe[gi] = 1'b0;
					end
				endcase
				// Enable low or unserved pin leaves it high impedance
				if (!hw_en || !PIN_MASK[gi]) begin
					drv_oe[gi] = 1'b0;
					drv_pu[gi] = 1'b0;
					drv_pd[gi] = 1'b0;
				end
			end
		end
	endgenerate

	// Byte lane mask for writes
	assign wmask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
		{8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};

	// Read decode; unmapped addresses read as zero
	always_comb begin
		if (I_AVS_ADDRESS == OFS_CFG) begin
			rd_mux = 32'(st_r.cfg);
		end else if (I_AVS_ADDRESS == OFS_OUT_LO) begin
			rd_mux = st_r.out_val[31:0];
		end else if (I_AVS_ADDRESS == OFS_OUT_HI) begin
			rd_mux = st_r.out_val[63:32];
		end else if (I_AVS_ADDRESS == OFS_LVL_LO) begin
			rd_mux = st_r.lvl[31:0];
		end else if (I_AVS_ADDRESS == OFS_LVL_HI) begin
			rd_mux = st_r.lvl[63:32];
		end else if (I_AVS_ADDRESS == OFS_DRV_IDX) begin
			rd_mux = 32'(st_r.drv_idx);
		end else if (I_AVS_ADDRESS == OFS_DRV_MODE) begin
			rd_mux = 32'(st_r.drv[st_r.drv_idx]);
		end else if (I_AVS_ADDRESS == OFS_STATUS) begin
			rd_mux = {23'h0, EFF_CNT, st_r.pin_out[0], fwd_lvl};
		end else begin
			rd_mux = 32'h0;
		end
	end

	// Next state of the whole block
	always_comb begin
		st_nxt = st_r;
		// Two-flop synchronisers for pins and control lines; only the
		// second flop of each pair is read by any other logic
		st_nxt.pin_m = pin_ext;
		st_nxt.pin_s = st_r.pin_m;
		st_nxt.ext_m = {I_OUT_RST, I_OUT_EN, I_OUT_CLK, I_IN_RST, I_IN_EN,
			I_IN_CLK};
		st_nxt.ext_s = st_r.ext_m;
		st_nxt.in_clk_d = st_r.ext_s[X_IN_CLK];
		st_nxt.out_clk_d = st_r.ext_s[X_OUT_CLK];
		// Sensed level always lands in readback
		st_nxt.lvl = in_if.q & PIN_MASK;
		// Level reaches on-chip logic only when connected
		st_nxt.hw_in = in_hw ? (in_if.q & PIN_MASK) : 64'h0;
		st_nxt.pin_out = drv_out;
		st_nxt.pin_oe = drv_oe;
		st_nxt.pu = drv_pu;
		st_nxt.pd = drv_pd;
		// Bus: take the request, answer one cycle later. A write lands on
		// the answering edge, while the master still holds address and data.
		if (st_r.wait_n) begin
			if (I_AVS_READ || I_AVS_WRITE) begin
				st_nxt.wait_n = 1'b0;
				st_nxt.rdata = I_AVS_READ ? rd_mux : 32'h0;
			end
		end else begin
			st_nxt.wait_n = 1'b1;
			if (I_AVS_WRITE) begin
				if (I_AVS_ADDRESS == OFS_CFG) begin
					st_nxt.cfg = (st_r.cfg & ~wmask[CFG_W-1:0]) |
						(I_AVS_WRITEDATA[CFG_W-1:0] & wmask[CFG_W-1:0]);
				end else if (I_AVS_ADDRESS == OFS_OUT_LO) begin
					st_nxt.out_val[31:0] = (st_r.out_val[31:0] & ~wmask) |
						(I_AVS_WRITEDATA & wmask);
				end else if (I_AVS_ADDRESS == OFS_OUT_HI) begin
					st_nxt.out_val[63:32] = (st_r.out_val[63:32] & ~wmask) |
						(I_AVS_WRITEDATA & wmask);
				end else if (I_AVS_ADDRESS == OFS_DRV_IDX) begin
					if (I_AVS_BYTEENABLE[0]) begin
						st_nxt.drv_idx = I_AVS_WRITEDATA[5:0];
					end
				end else if (I_AVS_ADDRESS == OFS_DRV_MODE) begin
					if (I_AVS_BYTEENABLE[0]) begin
						st_nxt.drv[st_r.drv_idx] = I_AVS_WRITEDATA[2:0];
					end
				end
			end
		end
	end

	// State register with synchronous reset
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			st_r <= '0;
			st_r.cfg <= CFG_RST;
			st_r.out_val <= OUT_VAL_RST;
			st_r.drv <= {MAX_PINS{DRV_RST}};
			st_r.drv_idx <= DRV_IDX_RST;
			st_r.wait_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign O_AVS_READDATA = st_r.rdata;
	assign O_AVS_WAITREQUEST = st_r.wait_n;
	assign O_HW_IN = st_r.hw_in[PIN_COUNT-1:0];
	assign O_PIN_OUT = st_r.pin_out[PIN_COUNT-1:0];
	assign O_PIN_OE = st_r.pin_oe[PIN_COUNT-1:0];
	assign O_PULL_UP = st_r.pu[PIN_COUNT-1:0];
	assign O_PULL_DN = st_r.pd[PIN_COUNT-1:0];
endmodule

// ===== include/cpg_pkg.sv
package cpg_pkg;
	// Pin counts
	localparam int MAX_PINS = 64;
	localparam int PORT_PINS = 8;
	localparam int DFLT_PINS = 1;
	// Register byte offsets
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_OUT_LO = 8'h04;
	localparam logic [7:0] OFS_OUT_HI = 8'h08;
	localparam logic [7:0] OFS_LVL_LO = 8'h0c;
	localparam logic [7:0] OFS_LVL_HI = 8'h10;
	localparam logic [7:0] OFS_DRV_IDX = 8'h14;
	localparam logic [7:0] OFS_DRV_MODE = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	// Configuration field positions
	localparam int CFG_W = 17;
	localparam int B_IN_CLK_EXT = 0;
	localparam int B_IN_EN_EXT = 1;
	localparam int B_IN_RST_EXT = 2;
	localparam int B_OUT_CLK_EXT = 3;
	localparam int B_OUT_EN_EXT = 4;
	localparam int B_OUT_RST_EXT = 5;
	localparam int B_IN_SYNC = 6;
	localparam int B_OUT_MODE = 8;
	localparam int B_OE_USED = 10;
	localparam int B_IN_HW = 11;
	localparam int B_OUT_HW = 12;
	localparam int B_BIDIR = 13;
	localparam int B_BUS_XCVR = 14;
	localparam int B_OUT_SYNC = 15;
	// External control lines, index into the synchroniser bank
	localparam int X_IN_CLK = 0;
	localparam int X_IN_EN = 1;
	localparam int X_IN_RST = 2;
	localparam int X_OUT_CLK = 3;
	localparam int X_OUT_EN = 4;
	localparam int X_OUT_RST = 5;
	localparam int X_W = 6;
	// Drive modes, eight of them
	typedef enum logic [2:0] {
		DM_HIZ_ANALOG = 3'h0,
		DM_HIZ_DIGITAL = 3'h1,
		DM_PULL_UP = 3'h2,
		DM_PULL_DOWN = 3'h3,
		DM_OD_LOW = 3'h4,
		DM_OD_HIGH = 3'h5,
		DM_STRONG = 3'h6,
		DM_PULL_UPDN = 3'h7
	} cpg_drive_e;
	// Synchronisation depth
	typedef enum logic [1:0] {
		SY_DOUBLE = 2'h0,
		SY_SINGLE = 2'h1,
		SY_BYPASS = 2'h2
	} cpg_sync_e;
	// Source of the value put on the pin
	typedef enum logic [1:0] {
		OM_DATA = 2'h0,
		OM_CLOCK = 2'h1,
		OM_CLOCK_INV = 2'h2
	} cpg_omode_e;
	// Pin type chosen at build time
	typedef enum logic [1:0] {
		PT_OUTPUT = 2'h0,
		PT_INPUT = 2'h1,
		PT_ANALOG = 2'h2,
		PT_BIDIR = 2'h3
	} cpg_ptype_e;
	// Reset values
	localparam logic [63:0] OUT_VAL_RST = 64'h0;
	localparam logic [5:0] DRV_IDX_RST = 6'h0;
	localparam logic [1:0] IN_SYNC_RST = 2'h0;
	localparam logic [1:0] OUT_SYNC_RST = 2'h2;
endpackage

// ===== include/cpg_sync_if.sv
`timescale 1ns/1ps
// Carries one synchronisation stage's controls and data
interface cpg_sync_if;
	logic adv; // Stage clock tick
	logic en; // Stage clock enable
	logic rst; // Stage reset
	logic [1:0] mode; // Depth selection
	logic [63:0] d; // Data into the stage
	logic [63:0] q; // Data out of the stage
	modport stage (input adv, input en, input rst, input mode, input d,
		output q);
	modport ctrl (output adv, output en, output rst, output mode, output d,
		input q);
endinterface

// ===== hdl/cpg_sync_stage.sv
`timescale 1ns/1ps
// One- or two-flop synchronising stage with tick, enable and reset
module cpg_sync_stage (
	input wire logic i_clk,
	input wire logic i_rst,
	cpg_sync_if.stage s
);
	import cpg_pkg::*;

	// Whole stage state
	typedef struct packed {
		logic [63:0] f1; // First flop
		logic [63:0] f2; // Second flop
	} cpg_stage_s;

	cpg_stage_s st_r;
	cpg_stage_s st_nxt;

	// Next state: reset wins, then a ticked and enabled shift
	always_comb begin
		st_nxt = st_r;
		if (s.rst) begin
			st_nxt = '0;
		end else if (s.adv && s.en) begin
			st_nxt.f1 = s.d;
			st_nxt.f2 = st_r.f1;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Depth selection; bypass passes straight through
	always_comb begin
		if (s.mode == SY_BYPASS) begin
			s.q = s.d;
		end else if (s.mode == SY_SINGLE) begin
			s.q = st_r.f1;
		end else begin
			s.q = st_r.f2;
		end
	end
endmodule

// ===== verification/cpg_ext_net.sv
`timescale 1ns/1ps
// Board net behind each pad: device drive, outside driver, pulls, float
module cpg_ext_net #(
	parameter int N = 1
) (
	input wire logic i_clk,
	input wire logic [N-1:0] i_dev_out,
	input wire logic [N-1:0] i_dev_oe,
	input wire logic [N-1:0] i_dev_pu,
	input wire logic [N-1:0] i_dev_pd,
	input wire logic [N-1:0] i_ext_val,
	input wire logic [N-1:0] i_ext_oe,
	output logic [N-1:0] o_level
);
	logic [N-1:0] flt_r = '0; // Pattern seen on an undriven net
	// A floating line never keeps its last value
	always @(posedge i_clk) begin
		flt_r <= ~flt_r;
	end
	// Pad driver wins, then the outside driver, then pulls, else float
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (i_dev_oe[i] === 1'b1) begin
				o_level[i] = i_dev_out[i];
			end else if (i_ext_oe[i]) begin
				o_level[i] = i_ext_val[i];
			end else if (i_dev_pu[i] === 1'b1) begin
				o_level[i] = 1'b1;
			end else if (i_dev_pd[i] === 1'b1) begin
				o_level[i] = 1'b0;
			end else begin
				o_level[i] = flt_r[i];
			end
		end
	end
endmodule

// ===== verification/cpg_pin_group_properties.sv
`timescale 1ns/1ps
// Watches the register handshake and the pad outputs
module cpg_pin_group_chk #(
	parameter int PIN_COUNT = 1,
	parameter bit SPANNING = 1'b0
) (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic [7:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] O_AVS_READDATA,
	input wire logic O_AVS_WAITREQUEST,
	input wire logic [PIN_COUNT-1:0] O_PIN_OE,
	input wire logic [PIN_COUNT-1:0] O_PULL_UP,
	input wire logic [PIN_COUNT-1:0] O_PULL_DN
);
	logic req; // A bus request is present
	assign req = I_AVS_READ || I_AVS_WRITE;
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_SYS_RST);
	a_answer_next: assert property (
		req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
		else $error("request not answered in the next cycle");
	a_idle_wait: assert property (
		!req && O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("answer without a request");
	a_low_once: assert property (
		!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	a_data_hold: assert property (
		O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST |-> $stable(O_AVS_READDATA))
		else $error("read data moved without an answer");
	a_unmapped_zero: assert property (
		I_AVS_READ && !O_AVS_WAITREQUEST && I_AVS_ADDRESS > 8'h1c
		|-> O_AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	a_pull_excl: assert property (
		(O_PULL_UP & O_PULL_DN) == '0)
		else $error("both pulls on one pad");
	a_port_limit: assert property (
		PIN_COUNT > 8 && !SPANNING
		|-> ((O_PIN_OE | O_PULL_UP | O_PULL_DN) >> 8) == '0)
		else $error("pad beyond one port is active");
	a_reset_quiet: assert property (
		$fell(I_SYS_RST) |-> O_AVS_WAITREQUEST && O_PIN_OE == '0)
		else $error("pads or bus active out of reset");
endmodule
bind cpg_pin_group cpg_pin_group_chk #(.PIN_COUNT(PIN_COUNT),
	.SPANNING(SPANNING)) u_chk (.I_CLK, .I_SYS_RST, .I_AVS_ADDRESS,
	.I_AVS_READ, .I_AVS_WRITE, .O_AVS_READDATA, .O_AVS_WAITREQUEST,
	.O_PIN_OE, .O_PULL_UP, .O_PULL_DN);

// ===== verification/tb_cpg_pin_group.sv
`timescale 1ns/1ps
// Self-checking bench for the pin group
module tb_cpg_pin_group;
	import cpg_pkg::*;
	localparam int N = 10; // More pins than one port holds
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wait_req;
	logic xclk = 1'b0; // Slow clock for the stage clock inputs
	logic xdiv = 1'b0;
	logic in_run = 1'b1; // Lets the input stage clock toggle
	logic in_en = 1'b1;
	logic in_rst = 1'b0;
	logic out_en = 1'b1;
	logic out_rst = 1'b0;
	logic [N-1:0] hw_out = '0;
	logic [N-1:0] hw_oe = '0;
	logic [N-1:0] ext_val = '0;
	logic [N-1:0] ext_oe = '0;
	logic [N-1:0] hw_in, lvl, pout, poe, pup, pdn;
	logic [31:0] q;
	int errors = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	// Stage clock of a quarter of the system rate
	always @(posedge clk) begin
		xdiv <= ~xdiv;
		if (xdiv) xclk <= ~xclk;
	end
	cpg_pin_group #(.PIN_COUNT(N), .SPANNING(1'b0), .PIN_TYPE(PT_OUTPUT)) dut (
		.I_CLK(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
		.I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hf),
		.O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_req),
		.I_IN_CLK(in_run & xclk), .I_IN_EN(in_en), .I_IN_RST(in_rst),
		.I_OUT_CLK(xclk), .I_OUT_EN(out_en), .I_OUT_RST(out_rst),
		.I_HW_OUT(hw_out), .I_HW_OE(hw_oe), .O_HW_IN(hw_in), .I_PIN_IN(lvl),
		.O_PIN_OUT(pout), .O_PIN_OE(poe), .O_PULL_UP(pup), .O_PULL_DN(pdn));
	cpg_ext_net #(.N(N)) u_net (.i_clk(clk), .i_dev_out(pout),
		.i_dev_oe(poe), .i_dev_pu(pup), .i_dev_pd(pdn),
		.i_ext_val(ext_val), .i_ext_oe(ext_oe), .o_level(lvl));
	// Compares and counts
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// One bus transfer, held until waitrequest is sampled low
	task automatic avs(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= ~w;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 40);
		r = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 40) chk("waitrequest", 32'h1, 32'h0);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		avs(1'b1, a, d, r);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic set_modes(input cpg_drive_e m);
		for (int i = 0; i < 8; i++) begin
			wreg(OFS_DRV_IDX, 32'(i));
			wreg(OFS_DRV_MODE, 32'(m));
		end
	endtask
	// Pin 0 as {enable, driven data, pull up, pull down}
	function automatic logic [31:0] pad0();
		return {28'h0, poe[0], poe[0] & pout[0], pup[0], pdn[0]};
	endfunction
	function automatic logic [31:0] drv_exp(input int m, input logic d);
		case (m)
			2: return {28'h0, ~d, 1'b0, 2'h2};
			3: return {28'h0, d, d, 2'h1};
			4: return {28'h0, ~d, 3'h0};
			5: return {28'h0, d, d, 2'h0};
			6: return {28'h0, 1'b1, d, 2'h0};
			7: return {28'h0, 2'h0, d, ~d};
			default: return 32'h0;
		endcase
	endfunction
	task automatic t_reset;
		avs(1'b0, OFS_CFG, 32'h0, q);
		chk("cfg reset", q, 32'h00010000);
		avs(1'b0, OFS_DRV_MODE, 32'h0, q);
		chk("mode reset", q, 32'(DM_STRONG));
		avs(1'b0, 8'h40, 32'h0, q);
		chk("unmapped", q, 32'h0);
		avs(1'b0, OFS_STATUS, 32'h0, q);
		chk("status", q, 32'(PORT_PINS) << 2);
	endtask
	task automatic t_data;
		wreg(OFS_OUT_LO, 32'h3a5);
		cyc(3);
		chk("pad enable", 32'(poe), 32'h0ff);
		chk("pad data", 32'(pout & poe), 32'h0a5);
		cyc(4);
		chk("hw input off", 32'(hw_in), 32'h0);
		avs(1'b0, OFS_LVL_LO, 32'h0, q);
		chk("level", q, 32'h0a5);
		avs(1'b0, OFS_OUT_LO, 32'h0, q);
		chk("out value", q, 32'h3a5);
		wreg(OFS_OUT_HI, 32'h5a5a5a5a);
		avs(1'b0, OFS_OUT_HI, 32'h0, q);
		chk("out high", q, 32'h5a5a5a5a);
		avs(1'b0, OFS_LVL_HI, 32'h0, q);
		chk("level high", q, 32'h0);
	endtask
	task automatic t_modes;
		for (int m = 0; m < 8; m++) begin
			wreg(OFS_DRV_MODE, 32'(m));
			avs(1'b0, OFS_DRV_MODE, 32'h0, q);
			chk("mode", q, 32'(m));
			for (int d = 0; d < 2; d++) begin
				wreg(OFS_OUT_LO, 32'(d));
				cyc(3);
				chk("drive", pad0(), drv_exp(m, d[0]));
			end
		end
		wreg(OFS_CFG, 32'h00014000);
		wreg(OFS_DRV_MODE, 32'(DM_PULL_UP));
		wreg(OFS_OUT_LO, 32'h0);
		cyc(3);
		chk("transceiver", pad0(), drv_exp(4, 1'b0));
		wreg(OFS_CFG, 32'h00010000);
	endtask
	task automatic t_sync;
		int lat[3] = '{3, 4, 5};
		set_modes(DM_HIZ_DIGITAL);
		avs(1'b0, OFS_DRV_IDX, 32'h0, q);
		chk("mode index", q, 32'h7);
		ext_oe <= '1;
		for (int s = 0; s < 3; s++) begin
			wreg(OFS_CFG, 32'h00010800 | (32'(2 - s) << 6));
			ext_val <= 10'h0c3;
			cyc(8);
			ext_val <= 10'h03c;
			cyc(lat[s]);
			chk("input held", 32'(hw_in), 32'h0c3);
			cyc(1);
			chk("input path", 32'(hw_in), 32'h03c);
		end
	endtask
	task automatic t_bidir;
		logic [31:0] cfgs[2] = '{32'h00012480, 32'h00011c80};
		set_modes(DM_STRONG);
		hw_out <= 10'h00a;
		hw_oe <= 10'h00f;
		ext_val <= 10'h350;
		foreach (cfgs[i]) begin
			wreg(OFS_CFG, cfgs[i]);
			cyc(8);
			chk("pad enable", 32'(poe), 32'h00f);
			chk("pad data", 32'(pout & poe), 32'h00a);
			chk("shared pin", 32'(hw_in), 32'h05a);
		end
	endtask
	task automatic t_in_ctl;
		set_modes(DM_HIZ_DIGITAL);
		for (int b = 0; b < 3; b++) begin
			wreg(OFS_CFG, 32'h00010840 | (32'h1 << b));
			ext_val <= 10'h0c3;
			cyc(20);
			chk("stage pass", 32'(hw_in), 32'h0c3);
			in_run <= (b != 0);
			in_en <= (b != 1);
			in_rst <= (b == 2);
			cyc(8);
			ext_val <= 10'h03c;
			cyc(20);
			chk("stage blocked", 32'(hw_in), b == 2 ? 32'h0 : 32'h0c3);
			in_run <= 1'b1;
			in_en <= 1'b1;
			in_rst <= 1'b0;
			cyc(20);
			chk("stage freed", 32'(hw_in), 32'h03c);
		end
	endtask
	task automatic t_out_ctl;
		int tbl[4][3] = '{'{1, 0, 0}, '{1, 1, 12}, '{2, 0, 24}, '{2, 1, 12}};
		int hi;
		set_modes(DM_STRONG);
		for (int i = 0; i < 4; i++) begin
			out_en <= tbl[i][1][0];
			wreg(OFS_CFG, 32'h00010018 | (32'(tbl[i][0]) << 8));
			cyc(8);
			hi = 0;
			repeat (24) begin
				@(posedge clk);
				if (pout[0] === 1'b1) hi++;
			end
			chk("forwarded clock", 32'(hi), 32'(tbl[i][2]));
		end
		wreg(OFS_OUT_LO, 32'h1);
		wreg(OFS_CFG, 32'h00008020);
		cyc(8);
		chk("out stage", 32'(pout[0]), 32'h1);
		out_rst <= 1'b1;
		cyc(8);
		chk("out reset", 32'(pout[0]), 32'h0);
		out_rst <= 1'b0;
	endtask
	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		report_and_stop;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_data;
		t_modes;
		t_sync;
		t_bidir;
		t_in_ctl;
		t_out_ctl;
		report_and_stop;
	end
endmodule
